// ===== hdl/mgmt_reg_mem.sv
`include "phy_mii_params.svh"
module mgmt_reg_mem #(
  parameter int DEPTH = `MGMT_NUM_REGS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [4:0] addr,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData_r,
  output logic [15:0] ctlWord_r,
  output logic [15:0] portCfg_r
);
  logic [15:0] mem [DEPTH];
  logic [15:0] rdData_nxt;
  logic [15:0] ctlWord_nxt;
  logic [15:0] portCfg_nxt;

  always_comb begin
    rdData_nxt = mem[addr];
    ctlWord_nxt = ctlWord_r;
    portCfg_nxt = portCfg_r;
    if (wrEn && addr == `CTL_REG_IDX) begin
      ctlWord_nxt = wrData;
    end
    if (wrEn && addr == `PORT_CFG_REG_IDX) begin
      portCfg_nxt = wrData;
    end
    if (addr == `CTL_REG_IDX) begin
      rdData_nxt = ctlWord_r;
    end else if (addr == `PORT_CFG_REG_IDX) begin
      rdData_nxt = portCfg_r;
    end
  end

  // Plain words hold extension registers; no reset on the array keeps it RAM-like
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= 16'h0000;
      ctlWord_r <= `CTL_RESET_VAL;
      portCfg_r <= `PORT_CFG_RESET_VAL;
    end else begin
      rdData_r <= rdData_nxt;
      ctlWord_r <= ctlWord_nxt;
      portCfg_r <= portCfg_nxt;
    end
  end
endmodule : mgmt_reg_mem

// ===== hdl/phy_mii_params.svh
`ifndef PHY_MII_PARAMS_SVH
`define PHY_MII_PARAMS_SVH
`define MII_ERR_NIBBLE 4'he
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define MGMT_PREAMBLE_BITS 6'h20
`define MGMT_NUM_REGS 32
`define CTL_REG_IDX 5'h00
`define CTL_LOOPBACK_BIT 14
`define CTL_ANEG_BIT 12
`define CTL_DUPLEX_BIT 8
`define CTL_RESET_VAL 16'h1000
`define PORT_CFG_REG_IDX 5'h10
`define PORT_CFG_LBINH_BIT 8
`define PORT_CFG_RESET_VAL 16'h0000
`endif

// ===== hdl/phy_mii_pkg.sv
package phy_mii_pkg;
  typedef enum logic [1:0] {SYM_IDLE, SYM_START, SYM_END, SYM_BAD} line_sym_t;
  typedef enum {M_IDLE, M_PRE, M_HDR, M_TA, M_RD, M_WR} mgmt_state_t;
endpackage : phy_mii_pkg

// ===== hdl/phy_mii_status.sv
`include "phy_mii_params.svh"
// Operation
// - Carrier sense not tied to MII clocks
// - Carrier on receive; on transmit if half-duplex
// - Full-duplex: no own-transmit carrier, no collision
// - 100M: start delimiter raises, end drops carrier
// - Idle without end: drop carrier, error pulse
// - 10M: preamble raises, end-of-frame drops carrier
// - 100M bad symbol: error, nibble 1110
// - Transmit error sends H symbols on line
// - Collision when half-duplex transmit and receive
// - 10M half-duplex, no inhibit: echo transmit data
// - No echo at 100M, full-duplex, inhibit
// - Test loopback: line off, transmit returned
// - Test loopback needs loopback, full-duplex, no aneg
// - Management disable input ignores serial traffic
// - Address is base plus port number
// - Sixteen-bit management registers, standard set
// - MII clocks 25/2.5 MHz, sample on rise
module phy_mii_status #(
  parameter logic [4:0] PORT_NUM = 5'h00
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic linkClk,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic rxLineActive,
  input wire logic [1:0] rxSymKind,
  input wire logic [3:0] rxLineNibble,
  input wire logic rxPreambleOk,
  input wire logic rxEndOfFrame,
  input wire logic txEn,
  input wire logic txEr,
  input wire logic [3:0] txd,
  input wire logic mgmtPortDisable,
  input wire logic [3:0] baseAddrPins,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  output logic crs,
  output logic col,
  output logic rxDv,
  output logic rxEr,
  output logic [3:0] rxd,
  output logic lineTxHSym,
  output logic lineOutEnable,
  output logic [3:0] lineTxNibble,
  output logic testLoopback
);
  logic rstSync1_r, rstSync_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync_r <= rstSync1_r;
    end
  end
  logic lrst1_r, lrst_r;
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      lrst1_r <= 1'b0;
      lrst_r <= 1'b0;
    end else begin
      lrst1_r <= 1'b1;
      lrst_r <= lrst1_r;
    end
  end
  // Mode, disable and mgmt pins arrive from outside sys_clk: two flops each
  logic [11:0] pinS1_r, pinS_r;
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      pinS1_r <= 12'h000;
      pinS_r <= 12'h000;
    end else if (clkEn) begin
      pinS1_r <= {speed100, fullDuplex, mgmtPortDisable, mdc, mdioIn, txEn, baseAddrPins,
                  rxPreambleOk, rxEndOfFrame};
      pinS_r <= pinS1_r;
    end
  end
  logic sSpeed, sFull, sDis, sMdc, sMdio, sTxEn, sPre, sEof;
  logic [3:0] sBase;
  assign {sSpeed, sFull, sDis, sMdc, sMdio, sTxEn, sBase, sPre, sEof} = pinS_r;
  // ---------------- Management (sys_clk domain, MDC oversampled) ----------------
  logic mdcPrev_r;
  phy_mii_pkg::mgmt_state_t mState_r, mState_nxt;
  logic [5:0] mCnt_r, mCnt_nxt;
  logic [13:0] mHdr_r, mHdr_nxt;
  logic [15:0] mShift_r, mShift_nxt;
  logic mOut_nxt, mOe_nxt, wrEn_nxt, wrEn_r;
  logic [15:0] rdData, ctlWord, portCfg;
  logic [4:0] myAddr;
  // Base pins are address bits 4:1, port number added
  assign myAddr = 5'({sBase, 1'b0} + PORT_NUM);
  logic mdcRise;
  assign mdcRise = sMdc && !mdcPrev_r;
  mgmt_reg_mem #(.DEPTH(`MGMT_NUM_REGS)) regs (
    .clk(sys_clk),
    .rstn(rstSync_r),
    .wrEn(wrEn_r && clkEn),
    .addr(mHdr_r[4:0]),
    .wrData(mShift_r),
    .rdData_r(rdData),
    .ctlWord_r(ctlWord),
    .portCfg_r(portCfg)
  );
  always_comb begin
    mState_nxt = mState_r;
    mCnt_nxt = mCnt_r;
    mHdr_nxt = mHdr_r;
    mShift_nxt = mShift_r;
    mOut_nxt = mdioOut;
    mOe_nxt = mdioOe;
    wrEn_nxt = 1'b0;
    if (sDis) begin
      mState_nxt = phy_mii_pkg::M_IDLE;
      mOe_nxt = 1'b0;
      mCnt_nxt = 6'h00;
    end else if (mdcRise) begin
      unique case (mState_r)
        phy_mii_pkg::M_IDLE: begin
          mCnt_nxt = sMdio ? 6'(mCnt_r + 6'h01) : 6'h00;
          if (sMdio && mCnt_r == `MGMT_PREAMBLE_BITS - 6'h01) begin
            mState_nxt = phy_mii_pkg::M_PRE;
          end
        end
        phy_mii_pkg::M_PRE: begin
          if (!sMdio) begin
            mState_nxt = phy_mii_pkg::M_HDR;
            mCnt_nxt = 6'h00;
            mHdr_nxt = 14'h0000;
          end
        end
        phy_mii_pkg::M_HDR: begin
          mHdr_nxt = {mHdr_r[12:0], sMdio};
          mCnt_nxt = 6'(mCnt_r + 6'h01);
          if (mCnt_r == 6'h0c) begin
            mState_nxt = phy_mii_pkg::M_TA;
            mCnt_nxt = 6'h00;
          end
        end
        phy_mii_pkg::M_TA: begin
          // Header: start bit, op[1:0], phy[4:0], reg[4:0]
          mCnt_nxt = 6'(mCnt_r + 6'h01);
          if (mHdr_r[9:5] != myAddr) begin
            mState_nxt = phy_mii_pkg::M_IDLE;
            mCnt_nxt = 6'h00;
          end else if (mHdr_r[11:10] == `MGMT_OP_READ) begin
            mState_nxt = phy_mii_pkg::M_RD;
            mShift_nxt = rdData;
            mOe_nxt = 1'b1;
            mOut_nxt = 1'b0;
            mCnt_nxt = 6'h00;
          end else if (mCnt_r == 6'h01) begin
            mState_nxt = phy_mii_pkg::M_WR;
            mCnt_nxt = 6'h00;
          end
        end
        phy_mii_pkg::M_RD: begin
          mOut_nxt = mShift_r[15];
          mShift_nxt = {mShift_r[14:0], 1'b0};
          mCnt_nxt = 6'(mCnt_r + 6'h01);
          if (mCnt_r == 6'h10) begin
            mOe_nxt = 1'b0;
            mState_nxt = phy_mii_pkg::M_IDLE;
            mCnt_nxt = 6'h00;
          end
        end
        phy_mii_pkg::M_WR: begin
          mShift_nxt = {mShift_r[14:0], sMdio};
          mCnt_nxt = 6'(mCnt_r + 6'h01);
          if (mCnt_r == 6'h0f) begin
            wrEn_nxt = (mHdr_r[11:10] == `MGMT_OP_WRITE);
            mState_nxt = phy_mii_pkg::M_IDLE;
            mCnt_nxt = 6'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      mdcPrev_r <= 1'b0;
      mState_r <= phy_mii_pkg::M_IDLE;
      mCnt_r <= 6'h00;
      mHdr_r <= 14'h0000;
      mShift_r <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
      wrEn_r <= 1'b0;
    end else if (clkEn) begin
      mdcPrev_r <= sMdc;
      mState_r <= mState_nxt;
      mCnt_r <= mCnt_nxt;
      mHdr_r <= mHdr_nxt;
      mShift_r <= mShift_nxt;
      mdioOut <= mOut_nxt;
      mdioOe <= mOe_nxt;
      wrEn_r <= wrEn_nxt;
    end
  end
  // ---------------- Mode decode (sys_clk) ----------------
  logic tstLb_nxt, opLb_nxt, opLb_r;
  always_comb begin
    tstLb_nxt = ctlWord[`CTL_LOOPBACK_BIT] && ctlWord[`CTL_DUPLEX_BIT]
                && !ctlWord[`CTL_ANEG_BIT];
    // Operational echo only at 10M half-duplex with inhibit clear
    opLb_nxt = !sSpeed && !sFull && !portCfg[`PORT_CFG_LBINH_BIT];
  end
  // ---------------- Carrier and collision (sys_clk, not MII clocks) -------------
  logic rxLbSync1_r, rxLbSync_r;
  logic crs100_r, crs_nxt, col_nxt, rxActive;
  logic eofPrev_r;
  logic crs10_r, crs10_nxt;
  always_comb begin
    // Preamble raises, end-of-frame edge drops
    crs10_nxt = crs10_r;
    if (sPre) begin
      crs10_nxt = 1'b1;
    end
    if (sEof && !eofPrev_r) begin
      crs10_nxt = 1'b0;
    end
    rxActive = sSpeed ? rxLbSync_r : crs10_r;
    crs_nxt = rxActive || (sTxEn && !sFull);
    col_nxt = !sFull && sTxEn && rxActive;
  end

  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      rxLbSync1_r <= 1'b0;
      rxLbSync_r <= 1'b0;
      eofPrev_r <= 1'b0;
      crs10_r <= 1'b0;
      crs <= 1'b0;
      col <= 1'b0;
      opLb_r <= 1'b0;
      testLoopback <= 1'b0;
    end else if (clkEn) begin
      rxLbSync1_r <= crs100_r;
      rxLbSync_r <= rxLbSync1_r;
      eofPrev_r <= sEof;
      crs10_r <= crs10_nxt;
      crs <= crs_nxt;
      col <= col_nxt;
      opLb_r <= opLb_nxt;
      testLoopback <= tstLb_nxt;
    end
  end
  // ---------------- Link clock domain (receive/transmit clock) ----------------
  logic [1:0] lbS1_r, lbS_r;
  logic crs100_nxt, rxEr_nxt, rxDv_nxt, hSym_nxt, lineOe_nxt;
  logic [3:0] rxd_nxt, lineTx_nxt;
  always_comb begin
    crs100_nxt = crs100_r;
    rxEr_nxt = 1'b0;
    rxDv_nxt = crs100_r;
    rxd_nxt = rxLineNibble;
    unique case (phy_mii_pkg::line_sym_t'(rxSymKind))
      phy_mii_pkg::SYM_START: crs100_nxt = rxLineActive;
      phy_mii_pkg::SYM_END: crs100_nxt = 1'b0;
      phy_mii_pkg::SYM_IDLE: begin
        crs100_nxt = 1'b0;
        rxEr_nxt = crs100_r;
      end
      phy_mii_pkg::SYM_BAD: begin
        rxEr_nxt = 1'b1;
        rxd_nxt = `MII_ERR_NIBBLE;
      end
    endcase
    if (lbS_r[1] || lbS_r[0]) begin
      rxd_nxt = txd;
      rxDv_nxt = txEn;
      rxEr_nxt = 1'b0;
    end
    hSym_nxt = txEr && txEn && !lbS_r[1];
    lineOe_nxt = !lbS_r[1];
    lineTx_nxt = txd;
  end

  always_ff @(posedge linkClk or negedge lrst_r) begin
    if (!lrst_r) begin
      lbS1_r <= 2'h0;
      lbS_r <= 2'h0;
      crs100_r <= 1'b0;
      rxEr <= 1'b0;
      rxDv <= 1'b0;
      rxd <= 4'h0;
      lineTxHSym <= 1'b0;
      lineOutEnable <= 1'b0;
      lineTxNibble <= 4'h0;
    end else begin
      lbS1_r <= {testLoopback, opLb_r};
      lbS_r <= lbS1_r;
      crs100_r <= crs100_nxt;
      rxEr <= rxEr_nxt;
      rxDv <= rxDv_nxt;
      rxd <= rxd_nxt;
      lineTxHSym <= hSym_nxt;
      lineOutEnable <= lineOe_nxt;
      lineTxNibble <= lineTx_nxt;
    end
  end

  a_fd_no_col: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    clkEn && sFull |=> !col) else $error("collision in full duplex");
  a_col_cause: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    col |-> $past(!sFull && sTxEn)) else $error("collision without cause");
  a_crs_tx_half: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    clkEn && sTxEn && !sFull |=> crs) else $error("no carrier on half tx");
  a_bad_sym: assert property (@(posedge linkClk) disable iff (!lrst_r)
    rxSymKind == 2'h3 && lbS_r == 2'h0 |=> rxEr && rxd == 4'he)
    else $error("bad symbol not flagged");
  a_idle_err: assert property (@(posedge linkClk) disable iff (!lrst_r)
    rxEr && !$past(rxSymKind == 2'h3) && rxSymKind != 2'h3 |=> !rxEr)
    else $error("idle error not one cycle");
  a_start_crs: assert property (@(posedge linkClk) disable iff (!lrst_r)
    rxSymKind == 2'h1 && rxLineActive |=> crs100_r) else $error("start missed");
  a_tx_err_h: assert property (@(posedge linkClk) disable iff (!lrst_r)
    txEr && txEn && !lbS_r[1] |=> lineTxHSym) else $error("no H symbols");
  a_test_lb_off: assert property (@(posedge linkClk) disable iff (!lrst_r)
    lbS_r[1] |=> !lineOutEnable) else $error("line on in test loopback");
  a_dis_quiet: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    clkEn && sDis |=> !mdioOe ##1 !mdioOe) else $error("mgmt active while disabled");
  a_tlb_cond: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    clkEn && !ctlWord[`CTL_DUPLEX_BIT] |=> !testLoopback) else $error("bad loopback");
  c_col: cover property (@(posedge sys_clk) disable iff (!rstSync_r) col);
  c_read: cover property (@(posedge sys_clk) disable iff (!rstSync_r) mdioOe);
  c_write: cover property (@(posedge sys_clk) disable iff (!rstSync_r) wrEn_r);
  c_echo: cover property (@(posedge linkClk) disable iff (!lrst_r) lbS_r[0] && txEn);
endmodule : phy_mii_status

// ===== test/mgmt_ctrl_model.sv
`include "phy_mii_params.svh"
module mgmt_ctrl_model (
  input wire logic clk,
  input wire logic mdioLine,
  output logic mdc,
  output logic ctrlOe,
  output logic ctrlBit
);
  timeunit 1ns;
  timeprecision 100ps;
  // Twelve system clocks a half period keeps the management clock near 10 MHz
  localparam int HALF = 12;
  initial begin
    mdc = 1'b0;
    ctrlOe = 1'b0;
    ctrlBit = 1'b1;
  end
  // Data changes while the clock is low, is sampled just before it rises
  task automatic tick(input logic drive, input logic b, output logic seen);
    ctrlOe = drive;
    ctrlBit = b;
    repeat (HALF) @(negedge clk);
    seen = mdioLine;
    mdc = 1'b1;
    repeat (HALF) @(negedge clk);
    mdc = 1'b0;
  endtask : tick
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regIdx,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic wr;
    wr = (op != `MGMT_OP_READ);
    hdr = {2'h1, op, phy, regIdx};
    for (int i = 0; i < 32; i++) tick(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) tick(1'b1, hdr[i], s);
    tick(wr, 1'b1, s);
    tick(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      tick(wr, wd[i], s);
      rd[i] = s;
    end
    ctrlOe = 1'b0;
    // Let an edge pass so a following frame never re-drives the line in the same step
    @(negedge clk);
  endtask : xfer
endmodule : mgmt_ctrl_model

// ===== test/tb_top.sv
`include "phy_mii_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] PORT = 5'h01;
  logic sys_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rstn = 1'b0;
  logic speed100 = 1'b0;
  logic fullDuplex = 1'b0;
  logic rxLineActive = 1'b0;
  logic [1:0] rxSymKind = 2'h0;
  logic [3:0] rxLineNibble = 4'h0;
  logic rxPreambleOk = 1'b0;
  logic rxEndOfFrame = 1'b0;
  logic txEn = 1'b0;
  logic txEr = 1'b0;
  logic [3:0] txd = 4'h0;
  logic mgmtPortDisable = 1'b0;
  logic [3:0] baseAddrPins = 4'h0;
  logic mdc, mdioIn, mdioOut, mdioOe, crs, col, rxDv, rxEr, lineTxHSym, lineOutEnable;
  logic testLoopback, ctrlOe, ctrlBit;
  logic [3:0] rxd, lineTxNibble;
  logic [15:0] rd, wv, erBase;
  logic [15:0] erCount = 16'h0000;
  logic [1:0] crsMac_r = 2'h0;
  logic [1:0] colMac_r = 2'h0;
  logic [15:0] ctlVals [4] = '{16'h4100, 16'h5100, 16'h4000, 16'h0100};
  logic [4:0] phy;
  int errors = 0;
  int checked = 0;
  int seed = 97;
  always #2 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #32 linkClk = ~linkClk;
  end
  // Open-drain line with a pull-up: nobody driving reads as one
  assign mdioIn = mdioOe ? mdioOut : (ctrlOe ? ctrlBit : 1'b1);
  always @(posedge linkClk) if (rxEr === 1'b1) erCount <= erCount + 16'h0001;
  // The MAC sees carrier and collision only through two flops of its own clock
  always @(posedge linkClk) begin
    crsMac_r <= {crsMac_r[0], crs};
    colMac_r <= {colMac_r[0], col};
  end
  phy_mii_status #(.PORT_NUM(PORT)) u_phy_mii_status (.sys_clk(sys_clk), .rstn(rstn),
    .clkEn(1'b1), .linkClk(linkClk), .speed100(speed100), .fullDuplex(fullDuplex),
    .rxLineActive(rxLineActive), .rxSymKind(rxSymKind), .rxLineNibble(rxLineNibble),
    .rxPreambleOk(rxPreambleOk), .rxEndOfFrame(rxEndOfFrame), .txEn(txEn), .txEr(txEr),
    .txd(txd), .mgmtPortDisable(mgmtPortDisable), .baseAddrPins(baseAddrPins), .mdc(mdc),
    .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .crs(crs), .col(col), .rxDv(rxDv),
    .rxEr(rxEr), .rxd(rxd), .lineTxHSym(lineTxHSym), .lineOutEnable(lineOutEnable),
    .lineTxNibble(lineTxNibble), .testLoopback(testLoopback));
  mgmt_ctrl_model u_mgmt_ctrl_model (.clk(sys_clk), .mdioLine(mdioIn), .mdc(mdc),
    .ctrlOe(ctrlOe), .ctrlBit(ctrlBit));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic chkb(input logic seen, input logic exp, input string msg);
    check({15'h0000, seen}, {15'h0000, exp}, msg);
  endtask : chkb
  task automatic conclude;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic settle;
    repeat (3) @(posedge linkClk);
    repeat (8) @(negedge sys_clk);
  endtask : settle
  task automatic mwr(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] x;
    u_mgmt_ctrl_model.xfer(`MGMT_OP_WRITE, phy, r, d, x);
  endtask : mwr
  task automatic mrd(input logic [4:0] r, output logic [15:0] d);
    u_mgmt_ctrl_model.xfer(`MGMT_OP_READ, phy, r, 16'h0000, d);
  endtask : mrd
  // Transmit nibble is never zero so an echo cannot match an idle receive path
  task automatic txOn(input logic b);
    @(negedge linkClk);
    txEn = b;
    txd = 4'($unsigned($random(seed)) % 15 + 1);
    rxLineNibble = ~txd;
    settle();
  endtask : txOn
  task automatic rxBegin;
    @(negedge linkClk);
    rxLineActive = speed100;
    rxSymKind = speed100 ? 2'h1 : 2'h0;
    rxPreambleOk = ~speed100;
    settle();
  endtask : rxBegin
  task automatic rxEnd(input logic viaIdle);
    @(negedge linkClk);
    erBase = erCount;
    rxSymKind = viaIdle ? 2'h0 : 2'h2;
    rxEndOfFrame = ~speed100;
    rxPreambleOk = 1'b0;
    @(negedge linkClk);
    rxSymKind = 2'h0;
    rxLineActive = 1'b0;
    rxEndOfFrame = 1'b0;
    settle();
  endtask : rxEnd
  initial begin
    #200us;
    errors++;
    conclude();
  end
  initial begin
    baseAddrPins = 4'($random(seed));
    phy = {baseAddrPins, 1'b0} + PORT;
    repeat (8) @(negedge sys_clk);
    repeat (2) @(posedge linkClk);
    @(negedge sys_clk);
    rstn = 1'b1;
    repeat (20) @(negedge sys_clk);
    mrd(`CTL_REG_IDX, rd);
    check(rd, `CTL_RESET_VAL, "control word reset");
    mrd(`PORT_CFG_REG_IDX, rd);
    check(rd, `PORT_CFG_RESET_VAL, "port config reset");
    wv = 16'($random(seed));
    mwr(5'h05, wv);
    mrd(5'h05, rd);
    check(rd, wv, "register write then read");
    u_mgmt_ctrl_model.xfer(`MGMT_OP_READ, phy ^ 5'h01, 5'h05, 16'h0000, rd);
    check(rd, 16'hffff, "foreign address answered");
    mgmtPortDisable = 1'b1;
    mwr(5'h05, ~wv);
    mrd(5'h05, rd);
    check(rd, 16'hffff, "answer while disabled");
    mgmtPortDisable = 1'b0;
    settle();
    mrd(5'h05, rd);
    check(rd, wv, "write taken while disabled");
    u_mgmt_ctrl_model.xfer(2'h3, phy, 5'h05, ~wv, rd);
    mrd(5'h05, rd);
    check(rd, wv, "write with undefined opcode");
    for (int m = 0; m < 4; m++) begin
      @(negedge sys_clk);
      {speed100, fullDuplex} = 2'(m);
      settle();
      txOn(1'b1);
      chkb(crs, ~fullDuplex, "carrier on transmit");
      chkb(col, 1'b0, "collision on transmit only");
      chkb(rxd === txd, ~speed100 & ~fullDuplex, "operational echo");
      rxBegin();
      chkb(crs, 1'b1, "carrier on receive");
      chkb(col, ~fullDuplex, "collision");
      chkb(crsMac_r[1], 1'b1, "carrier at MAC");
      chkb(colMac_r[1], ~fullDuplex, "collision at MAC");
      txOn(1'b0);
      chkb(col, 1'b0, "collision on receive only");
      rxEnd(1'b0);
      chkb(crs, 1'b0, "carrier after end delimiter");
      check(erCount - erBase, 16'h0000, "error on clean end");
    end
    mwr(`PORT_CFG_REG_IDX, 16'h0100);
    {speed100, fullDuplex} = 2'h0;
    txOn(1'b1);
    chkb(rxd === txd, 1'b0, "echo while inhibited");
    txOn(1'b0);
    speed100 = 1'b1;
    rxBegin();
    rxEnd(1'b1);
    chkb(crs, 1'b0, "carrier after idle without end");
    check(erCount - erBase, 16'h0001, "error pulse length");
    rxBegin();
    @(negedge linkClk);
    rxSymKind = 2'h3;
    repeat (2) @(posedge linkClk);
    #1;
    chkb(rxEr, 1'b1, "error on bad symbol");
    check({12'h000, rxd}, {12'h000, `MII_ERR_NIBBLE}, "nibble on bad symbol");
    rxEnd(1'b0);
    @(negedge linkClk);
    txEn = 1'b1;
    txEr = 1'b1;
    repeat (2) @(posedge linkClk);
    #1;
    chkb(lineTxHSym, 1'b1, "H symbols on transmit error");
    check({12'h000, lineTxNibble}, {12'h000, txd}, "line nibble");
    txEr = 1'b0;
    txOn(1'b0);
    chkb(lineTxHSym, 1'b0, "H symbols after error");
    fullDuplex = 1'b1;
    for (int k = 0; k < 4; k++) begin
      mwr(`CTL_REG_IDX, ctlVals[k]);
      txOn(1'b1);
      chkb(testLoopback, k == 0, "test loopback entry");
      chkb(lineOutEnable, k != 0, "line output in test loopback");
      chkb(rxDv, k == 0, "receive valid in test loopback");
      chkb(rxd === txd, k == 0, "test loopback data");
      txOn(1'b0);
    end
    conclude();
  end
endmodule : tb_top
